// File: hw/axs_slave.sv
// Burst memory slave on five channels,
// with low-power handshake and APB control.
// Assumes one global clock and a master
// that keeps its own obligations.
//
// Function
// - data width is one of 8 to 1024 bits, fixed by parameter.
// - each strobe bit enables exactly its own byte lane of write data.
// - slave raises write ready only while it can take a beat.
// - write response ID equals the write address ID it answers.
// - write response uses only okay, exokay, slave error, decode error.
// - write response valid high only with a real response; master readies.
// - read request gives start address; slave derives later addresses.
// - read length sets exactly how many beats are returned.
// - read size sets bytes moved per beat.
// - next read address comes from burst type and size.
// - read address fields hold stable until read address ready.
// - read data ID equals the read request ID being answered.
// - read beat status limited to the four defined responses.
// - read last marks only the final beat of each burst.
// - read valid only with real data; master readies for data.
// - clock controller requests low power; peripheral acknowledges.
// - clock-active output high while the clock is needed.
// - everything is sampled on the rising edge of one clock.
// - reset is asserted while low.
// - a transfer happens only when valid and ready are both high.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "axs_regs.svh"

module axs_slave #(
   parameter int DATA_W = 32,
   parameter int MEM_WORDS = 256
) (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic ce,
   // Write address channel
   input wire logic [3:0] awid,
   input wire logic [31:0] awaddr,
   input wire logic [3:0] awlen,
   input wire logic [2:0] awsize,
   input wire logic [1:0] awburst,
   input wire logic [1:0] awlock,
   input wire logic [3:0] awcache,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   // Write data channel
   input wire logic [3:0] wid,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [DATA_W/8-1:0] wstrb,
   input wire logic wlast,
   input wire logic wvalid,
   output logic wready,
   // Write response channel
   output logic [3:0] bid,
   output axs_pkg::axs_resp_t bresp,
   output logic bvalid,
   input wire logic bready,
   // Read address channel
   input wire logic [3:0] arid,
   input wire logic [31:0] araddr,
   input wire logic [3:0] arlen,
   input wire logic [2:0] arsize,
   input wire logic [1:0] arburst,
   input wire logic [1:0] arlock,
   input wire logic [3:0] arcache,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   // Read data channel
   output logic [3:0] rid,
   output logic [DATA_W-1:0] rdata,
   output axs_pkg::axs_resp_t rresp,
   output logic rlast,
   output logic rvalid,
   input wire logic rready,
   // Low-power handshake
   input wire logic csysreq,
   output logic csysack,
   output logic cactive,
   // APB control
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import axs_pkg::*;

   localparam int STRB_W = DATA_W / 8;
   localparam int BYTE_LSB = $clog2(STRB_W);
   localparam int IDX_W = $clog2(MEM_WORDS);
   localparam logic [31:0] MEM_BYTES = 32'(MEM_WORDS * STRB_W);
   localparam logic [2:0] MAX_SIZE = 3'(BYTE_LSB);

   // Next beat address; wrap keeps the burst inside its aligned window
   function automatic logic [31:0] axs_next_addr(input logic [31:0] a,
      input logic [2:0] sz, input logic [1:0] bt, input logic [3:0] ln);
      logic [31:0] step;
      logic [31:0] win;
      logic [31:0] inc;
      step = 32'h1 << sz;
      win = (({28'h0, ln} + 32'h1) << sz) - 32'h1;
      inc = (a & ~(step - 32'h1)) + step;
      case (bt)
         `AXS_BURST_FIXED: axs_next_addr = a;
         `AXS_BURST_WRAP: axs_next_addr = (a & ~win) | (inc & win);
         default: axs_next_addr = inc;
      endcase
   endfunction

   axs_wr_state_t wr_st_r;
   axs_rd_state_t rd_st_r;
   logic [3:0] wr_id_r;
   logic [31:0] wr_addr_r;
   logic [3:0] wr_len_r;
   logic [2:0] wr_size_r;
   logic [1:0] wr_burst_r;
   logic [3:0] wr_beat_r;
   logic wr_dec_r;
   logic wr_slv_r;
   axs_resp_t bresp_r;
   logic [3:0] rd_id_r;
   logic [31:0] rd_addr_r;
   logic [3:0] rd_len_r;
   logic [2:0] rd_size_r;
   logic [1:0] rd_burst_r;
   logic [3:0] rd_beat_r;
   logic rd_slv_r;
   logic [DATA_W-1:0] rdata_r;
   axs_resp_t rresp_r;
   logic rlast_r;
   logic rvalid_r;
   logic csysack_r;
   logic cactive_r;
   logic lp_state_r;
   logic [15:0] wr_count_r;
   logic [15:0] rd_count_r;
   logic err_inj;
   logic lp_en;
   logic aw_fire;
   logic w_fire;
   logic b_fire;
   logic ar_fire;
   logic r_fire;
   logic wr_hit;
   logic rd_hit;
   logic [IDX_W-1:0] wr_idx;
   logic [IDX_W-1:0] rd_idx;
   logic [DATA_W-1:0] rd_word;
   logic both_idle;

   //////////////////////////////////////////////////////////////////////////
   // Handshakes; ready depends only on state and ce, never on a valid input
   assign awready = ce & (wr_st_r == AXS_WR_IDLE) & !lp_state_r;
   assign wready = ce & (wr_st_r == AXS_WR_DATA);
   assign bvalid = (wr_st_r == AXS_WR_RESP);
   assign arready = ce & (rd_st_r == AXS_RD_IDLE) & !lp_state_r;
   assign aw_fire = awvalid & awready;
   assign w_fire = wvalid & wready;
   assign b_fire = ce & bvalid & bready;
   assign ar_fire = arvalid & arready;
   assign r_fire = ce & rvalid_r & rready;
   assign bid = wr_id_r;
   assign bresp = bresp_r;
   assign rid = rd_id_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;
   assign rlast = rlast_r;
   assign rvalid = rvalid_r;
   assign csysack = csysack_r;
   assign cactive = cactive_r;
   assign both_idle = (wr_st_r == AXS_WR_IDLE) & (rd_st_r == AXS_RD_IDLE);

   // Address decode; beyond the array is a decode error
   assign wr_hit = (wr_addr_r < MEM_BYTES);
   assign rd_hit = (rd_addr_r < MEM_BYTES);
   assign wr_idx = wr_addr_r[BYTE_LSB +: IDX_W];
   assign rd_idx = rd_addr_r[BYTE_LSB +: IDX_W];

   //////////////////////////////////////////////////////////////////////////
   // Byte-lane storage; each lane written only under its own strobe
   for (genvar n = 0; n < STRB_W; n++) begin : g_lane
      logic [7:0] lane_mem [MEM_WORDS];
      always_ff @(posedge ref_clk) begin
         if (w_fire & wr_hit & !err_inj & wstrb[n]) begin
            lane_mem[wr_idx] <= wdata[8*n +: 8];
         end
      end
      assign rd_word[8*n +: 8] = lane_mem[rd_idx];
   end

   //////////////////////////////////////////////////////////////////////////
   // Write sequence: address, beats until write last, one response
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_st_r <= AXS_WR_IDLE;
         wr_id_r <= 4'h0;
         wr_addr_r <= 32'h0;
         wr_len_r <= 4'h0;
         wr_size_r <= 3'h0;
         wr_burst_r <= 2'h0;
         wr_beat_r <= 4'h0;
         wr_dec_r <= 1'b0;
         wr_slv_r <= 1'b0;
         bresp_r <= `AXS_RESP_OKAY;
      end else if (ce) begin
         case (wr_st_r)
            AXS_WR_IDLE: begin
               if (aw_fire) begin
                  wr_id_r <= awid;
                  wr_addr_r <= awaddr;
                  wr_len_r <= awlen;
                  wr_size_r <= awsize;
                  wr_burst_r <= awburst;
                  wr_beat_r <= 4'h0;
                  wr_dec_r <= 1'b0;
                  wr_slv_r <= (awsize > MAX_SIZE) | (awburst == 2'h3);
                  wr_st_r <= AXS_WR_DATA;
               end
            end
            AXS_WR_DATA: begin
               if (w_fire) begin
                  // A beat past the length or an early last is flagged
                  if (wlast != (wr_beat_r == wr_len_r)) begin
                     wr_slv_r <= 1'b1;
                  end
                  if (!wr_hit) begin
                     wr_dec_r <= 1'b1;
                  end
                  if (wid != wr_id_r) begin
                     wr_slv_r <= 1'b1;
                  end
                  if (wr_beat_r != 4'hf) begin
                     wr_beat_r <= wr_beat_r + 4'h1;
                  end
                  wr_addr_r <= axs_next_addr(wr_addr_r, wr_size_r, wr_burst_r, wr_len_r);
                  if (wlast) begin
                     wr_st_r <= AXS_WR_RESP;
                     // Same-cycle faults are folded in here too
                     if (wr_dec_r | !wr_hit) begin
                        bresp_r <= `AXS_RESP_DECERR;
                     end else if (wr_slv_r | err_inj | (wid != wr_id_r) |
                                  (wr_beat_r != wr_len_r)) begin
                        bresp_r <= `AXS_RESP_SLVERR;
                     end else begin
                        bresp_r <= `AXS_RESP_OKAY;
                     end
                  end
               end
            end
            AXS_WR_RESP: begin
               if (b_fire) begin
                  wr_st_r <= AXS_WR_IDLE;
               end
            end
            default: wr_st_r <= AXS_WR_IDLE;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Read sequence: fetch a beat, present it, advance on acceptance.
   // Trades half throughput for a registered data path with no bypass.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_st_r <= AXS_RD_IDLE;
         rd_id_r <= 4'h0;
         rd_addr_r <= 32'h0;
         rd_len_r <= 4'h0;
         rd_size_r <= 3'h0;
         rd_burst_r <= 2'h0;
         rd_beat_r <= 4'h0;
         rd_slv_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= `AXS_RESP_OKAY;
         rlast_r <= 1'b0;
         rvalid_r <= 1'b0;
      end else if (ce) begin
         case (rd_st_r)
            AXS_RD_IDLE: begin
               if (ar_fire) begin
                  rd_id_r <= arid;
                  rd_addr_r <= araddr;
                  rd_len_r <= arlen;
                  rd_size_r <= arsize;
                  rd_burst_r <= arburst;
                  rd_beat_r <= 4'h0;
                  rd_slv_r <= (arsize > MAX_SIZE) | (arburst == 2'h3);
                  rd_st_r <= AXS_RD_FETCH;
               end
            end
            AXS_RD_FETCH: begin
               rdata_r <= rd_hit ? rd_word : '0;
               if (!rd_hit) begin
                  rresp_r <= `AXS_RESP_DECERR;
               end else if (rd_slv_r | err_inj) begin
                  rresp_r <= `AXS_RESP_SLVERR;
               end else begin
                  rresp_r <= `AXS_RESP_OKAY;
               end
               rlast_r <= (rd_beat_r == rd_len_r);
               rvalid_r <= 1'b1;
               rd_st_r <= AXS_RD_SEND;
            end
            AXS_RD_SEND: begin
               if (r_fire) begin
                  rvalid_r <= 1'b0;
                  rlast_r <= 1'b0;
                  if (rlast_r) begin
                     rd_st_r <= AXS_RD_IDLE;
                  end else begin
                     rd_beat_r <= rd_beat_r + 4'h1;
                     rd_addr_r <= axs_next_addr(rd_addr_r, rd_size_r, rd_burst_r,
                        rd_len_r);
                     rd_st_r <= AXS_RD_FETCH;
                  end
               end
            end
            default: rd_st_r <= AXS_RD_IDLE;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Low-power handshake; entry waits for both channels to drain, and a
   // disabled control bit acknowledges without stopping (a denial)
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         csysack_r <= 1'b1;
         lp_state_r <= 1'b0;
         cactive_r <= 1'b1;
      end else if (ce) begin
         if (!csysreq & csysack_r & both_idle) begin
            csysack_r <= 1'b0;
            lp_state_r <= lp_en;
         end else if (csysreq & !csysack_r) begin
            csysack_r <= 1'b1;
            lp_state_r <= 1'b0;
         end
         // Clock stays needed while anything is in flight or pending
         cactive_r <= !lp_state_r | !both_idle | awvalid | arvalid | wvalid;
      end
   end

   // Completed transaction counters, wrap at 16 bits
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_count_r <= 16'h0;
         rd_count_r <= 16'h0;
      end else begin
         if (b_fire) wr_count_r <= wr_count_r + 16'h1;
         if (r_fire & rlast_r) rd_count_r <= rd_count_r + 16'h1;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Control registers
   axs_apb_regs u_regs (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .ce(ce),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .ctrl_err_inj(err_inj),
      .ctrl_lp_en(lp_en),
      .stat_wbusy(wr_st_r != AXS_WR_IDLE),
      .stat_rbusy(rd_st_r != AXS_RD_IDLE),
      .stat_lp(lp_state_r),
      .wr_count(wr_count_r),
      .rd_count(rd_count_r)
   );

endmodule // axs_slave

`default_nettype wire

// File: hw/axs_regs.svh
// Constants of the burst slave port.
// Assumes inclusion by bare name.
`ifndef AXS_REGS_SVH
`define AXS_REGS_SVH

// Register byte offsets on the control bus
`define AXS_CTRL_OFS 8'h00
`define AXS_STATUS_OFS 8'h04
`define AXS_WCOUNT_OFS 8'h08
`define AXS_RCOUNT_OFS 8'h0c

// Control fields and reset value
`define AXS_CTRL_ERR_BIT 0
`define AXS_CTRL_LPEN_BIT 1
`define AXS_CTRL_RST 32'h0000_0002

// Status fields
`define AXS_STAT_WBUSY_BIT 0
`define AXS_STAT_RBUSY_BIT 1
`define AXS_STAT_LP_BIT 2

// Response codes
`define AXS_RESP_OKAY 2'h0
`define AXS_RESP_EXOKAY 2'h1
`define AXS_RESP_SLVERR 2'h2
`define AXS_RESP_DECERR 2'h3

// Burst types
`define AXS_BURST_FIXED 2'h0
`define AXS_BURST_INCR 2'h1
`define AXS_BURST_WRAP 2'h2

`endif

// File: hw/axs_pkg.sv
// Types of the burst slave port.
// Assumes the constants header sits beside it.
package axs_pkg;

   // Response field
   typedef logic [1:0] axs_resp_t;

   // Write side sequence
   typedef enum logic [1:0] {
      AXS_WR_IDLE = 2'b00,
      AXS_WR_DATA = 2'b01,
      AXS_WR_RESP = 2'b10
   } axs_wr_state_t;

   // Read side sequence
   typedef enum logic [1:0] {
      AXS_RD_IDLE = 2'b00,
      AXS_RD_FETCH = 2'b01,
      AXS_RD_SEND = 2'b10
   } axs_rd_state_t;

endpackage

// File: hw/axs_apb_regs.sv
// APB registers of the burst slave port.
// Assumes the port's clock and an APB master.
`timescale 1ns/10ps
`default_nettype none
`include "axs_regs.svh"

module axs_apb_regs (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Control out
   output logic ctrl_err_inj,
   output logic ctrl_lp_en,
   // Status in
   input wire logic stat_wbusy,
   input wire logic stat_rbusy,
   input wire logic stat_lp,
   input wire logic [15:0] wr_count,
   input wire logic [15:0] rd_count
);
   import axs_pkg::*;

   logic [31:0] ctrl_r;
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic acc;
   logic hit_ctrl;
   logic hit_stat;
   logic hit_wcnt;
   logic hit_rcnt;
   logic mapped;
   logic [31:0] rd_mux;

   //////////////////////////////////////////////////////////////////////////
   // Decode; access phase answers in its first cycle
   assign acc = ce & psel & penable;
   assign hit_ctrl = (paddr == `AXS_CTRL_OFS);
   assign hit_stat = (paddr == `AXS_STATUS_OFS);
   assign hit_wcnt = (paddr == `AXS_WCOUNT_OFS);
   assign hit_rcnt = (paddr == `AXS_RCOUNT_OFS);
   assign mapped = hit_ctrl | hit_stat | hit_wcnt | hit_rcnt;
   assign rd_mux = hit_ctrl ? ctrl_r :
                   hit_stat ? {29'h0, stat_lp, stat_rbusy, stat_wbusy} :
                   hit_wcnt ? {16'h0, wr_count} :
                   hit_rcnt ? {16'h0, rd_count} : 32'h0;
   assign pready = psel & penable;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r;
   assign ctrl_err_inj = ctrl_r[`AXS_CTRL_ERR_BIT];
   assign ctrl_lp_en = ctrl_r[`AXS_CTRL_LPEN_BIT];

   // Only the two control bits are writable, the rest read zero
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_r <= `AXS_CTRL_RST;
      end else if (acc & pwrite & hit_ctrl) begin
         ctrl_r <= {30'h0, pwdata[1:0]};
      end
   end

   // Read data and error held after the access for the bench to see
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata_r <= 32'h0;
         pslverr_r <= 1'b0;
      end else if (ce & psel & !penable) begin
         prdata_r <= pwrite ? 32'h0 : rd_mux;
         pslverr_r <= !mapped;
      end
   end

endmodule // axs_apb_regs

`default_nettype wire

// File: tb/axs_ready_model.sv
// Master-side bready and rready model.
// Assumes the bench clock and reset.
`timescale 1ns/10ps
`default_nettype none
module axs_ready_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Stall mode from the bench
   input wire logic slow,
   // Acceptance lines
   output logic bready,
   output logic rready
);
   logic [7:0] lfsr_r;
   // LFSR stalls exercise early and late acceptance
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         lfsr_r <= 8'h5a;
         bready <= 1'b0;
         rready <= 1'b0;
      end else begin
         lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
         bready <= !slow || lfsr_r[0];
         rready <= !slow || lfsr_r[3];
      end
   end
endmodule // axs_ready_model
`default_nettype wire

// File: tb/axs_slave_assertions.sv
// Checker of the burst slave port.
// Assumes it is bound onto axs_slave and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module axs_slave_chk #(
   parameter int DATA_W = 32
) (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic ce,
   // Write channels
   input wire logic [3:0] awid,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic wlast,
   input wire logic [3:0] bid,
   input wire axs_pkg::axs_resp_t bresp,
   input wire logic bvalid,
   input wire logic bready,
   // Read channels
   input wire logic [3:0] arid,
   input wire logic [3:0] arlen,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [3:0] rid,
   input wire logic [DATA_W-1:0] rdata,
   input wire axs_pkg::axs_resp_t rresp,
   input wire logic rlast,
   input wire logic rvalid,
   input wire logic rready,
   // Low power
   input wire logic csysreq,
   input wire logic csysack,
   input wire logic cactive
);
   import axs_pkg::*;
   logic [3:0] aw_id_r, ar_id_r, ar_len_r, beat_r;
   ////////////////////////////////////////////////////////////////////////////
   // Tags and beat count of open bursts
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         aw_id_r <= 4'h0;
         ar_id_r <= 4'h0;
         ar_len_r <= 4'h0;
         beat_r <= 4'h0;
      end else begin
         if (awvalid && awready) aw_id_r <= awid;
         if (arvalid && arready) {ar_id_r, ar_len_r, beat_r} <= {arid, arlen, 4'h0};
         else if (rvalid && rready && ce) beat_r <= beat_r + 4'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   sequence ar_take_s;
      arvalid && arready ##1 ce;
   endsequence
   sequence w_end_s;
      wvalid && wready && wlast;
   endsequence
   wr_ready_follow_a: assert property (awvalid && awready ##1 ce |-> wready)
      else $error("no wready");
   b_after_last_a: assert property (w_end_s |=> bvalid && !wready)
      else $error("no bvalid");
   b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable({bid, bresp}))
      else $error("b unstable");
   b_tag_a: assert property (bvalid |-> bid == aw_id_r)
      else $error("bid wrong");
   resp_code_a: assert property ((bvalid |-> bresp != 2'h1) and (rvalid |-> rresp != 2'h1))
      else $error("exokay seen");
   r_delay_a: assert property (ar_take_s |-> !rvalid ##1 rvalid)
      else $error("rvalid late");
   r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable({rdata, rlast, rid}))
      else $error("r unstable");
   r_tag_a: assert property (rvalid |-> rid == ar_id_r)
      else $error("rid wrong");
   r_last_a: assert property (rvalid |-> rlast == (beat_r == ar_len_r))
      else $error("rlast wrong");
   lp_ack_a: assert property (csysreq && !csysack && ce |=> csysack)
      else $error("no wake ack");
   clk_idle_a: assert property ($fell(cactive) |-> !csysack && !bvalid && !rvalid)
      else $error("cactive fell early");
endmodule // axs_slave_chk
bind axs_slave axs_slave_chk #(.DATA_W(DATA_W)) chk_u (.*);
`default_nettype wire

// File: tb/axs_slave_tb.sv
// Bench of the burst slave port.
// Assumes the package, header, checker and ready model.
`timescale 1ns/10ps
`default_nettype none
`include "axs_regs.svh"
module axs_slave_tb;
   import axs_pkg::*;
   logic ref_clk, rst_b, ce, slow, awvalid, awready, wlast, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rlast, rvalid, rready, csysreq, csysack, cactive;
   logic psel, penable, pwrite, pready, pslverr;
   logic [3:0] awid, awlen, awcache, wid, bid, arid, arlen, arcache, rid, wstrb;
   logic [2:0] awsize, awprot, arsize, arprot;
   logic [1:0] awburst, awlock, arburst, arlock;
   axs_resp_t bresp, rresp;
   logic [31:0] awaddr, araddr, wdata, rdata, pwdata, prdata;
   logic [7:0] paddr;
   logic [7:0] mem [0:1023];
   int failures, checks_done, nw, nr;
   axs_slave dut_u (.*);
   axs_ready_model peer_u (.*);
   ////////////////////////////////////////////////////////////////////////////
   // Clock; ce stutters only in stall mode
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) ce <= !slow || ($urandom % 4 != 0);
   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %0t: %h vs %h", $time, seen, exp);
      end
   endtask
   // One clock, hang-guarded; reads after it see the edge's samples
   task automatic step(inout int n);
      @(posedge ref_clk);
      n++;
      if (n > 300) begin
         failures++;
         tally_and_finish();
      end
   endtask
   function automatic logic [31:0] nxt(input logic [31:0] a, input logic [1:0] bt,
                                       input logic [3:0] ln);
      logic [31:0] w;
      w = ({28'h0, ln} + 32'h1) << 2;
      if (bt == `AXS_BURST_FIXED) return a;
      if (bt == `AXS_BURST_WRAP) return (a & ~(w - 1)) | ((a + 4) & (w - 1));
      return a + 32'h4;
   endfunction
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do step(n); while (!pready);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   // Write burst; reference memory follows writes of bursts expected to answer okay
   task automatic wr_burst(input logic [3:0] id, input logic [31:0] a, input logic [3:0] ln,
                           input logic [1:0] bt, input logic [3:0] wd, input logic [3:0] sm,
                           input axs_resp_t exp);
      int n;
      logic [3:0] s;
      logic [31:0] d;
      {awid, awaddr, awlen, awsize, awburst} <= {id, a, ln, 3'h2, bt};
      {awlock, awcache, awprot} <= 9'($urandom);
      awvalid <= 1'b1;
      n = 0;
      do step(n); while (!awready);
      awvalid <= 1'b0;
      for (int i = 0; i <= ln; i++) begin
         s = 4'($urandom) | sm;
         d = $urandom;
         wid <= wd;
         wdata <= d;
         wstrb <= s;
         wlast <= (i == ln);
         wvalid <= 1'b1;
         n = 0;
         do step(n); while (!wready);
         for (int k = 0; k < 4; k++) if (exp == `AXS_RESP_OKAY && s[k]) mem[a[9:0] + k] = d[8*k +: 8];
         a = nxt(a, bt, ln);
      end
      wvalid <= 1'b0;
      wlast <= 1'b0;
      n = 0;
      do step(n); while (!(bvalid && bready && ce));
      chk(32'(bresp), 32'(exp));
      nw++;
   endtask
   task automatic rd_burst(input logic [3:0] id, input logic [31:0] a, input logic [3:0] ln,
                           input logic [1:0] bt, input axs_resp_t exp);
      int n;
      {arid, araddr, arlen, arsize, arburst} <= {id, a, ln, 3'h2, bt};
      {arlock, arcache, arprot} <= 9'($urandom);
      arvalid <= 1'b1;
      n = 0;
      do step(n); while (!arready);
      arvalid <= 1'b0;
      for (int i = 0; i <= ln; i++) begin
         n = 0;
         do step(n); while (!(rvalid && rready && ce));
         chk(32'(rresp), 32'(exp));
         chk(32'(rlast), 32'(i == ln));
         if (exp == `AXS_RESP_OKAY) chk(rdata, {mem[a[9:0] + 3], mem[a[9:0] + 2], mem[a[9:0] + 1], mem[a[9:0]]});
         if (exp == `AXS_RESP_DECERR) chk(rdata, 32'h0);
         a = nxt(a, bt, ln);
      end
      nr++;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Registers, random bursts, errors, low power
   initial begin
      logic [31:0] rv, a;
      logic [3:0] ln;
      logic [1:0] bt;
      int n;
      void'($urandom(1));
      {rst_b, ce, slow, awvalid, wvalid, arvalid, psel, penable, pwrite, wlast} = 10'h100;
      {awid, awaddr, awlen, awsize, awburst, awlock, awcache, awprot, wid, wdata, wstrb} = '0;
      {arid, araddr, arlen, arsize, arburst, arlock, arcache, arprot, paddr, pwdata} = '0;
      csysreq = 1'b1;
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      apb(1'b0, `AXS_CTRL_OFS, 32'h0, rv);
      chk(rv, `AXS_CTRL_RST);
      apb(1'b0, 8'h10, 32'h0, rv);
      chk(32'(pslverr), 32'h1);
      wr_burst(4'h3, 32'h0, 4'hf, `AXS_BURST_INCR, 4'h3, 4'hf, `AXS_RESP_OKAY);
      for (int i = 0; i < 9; i++) begin
         slow <= i[0];
         bt = 2'(i % 3);
         ln = (bt == `AXS_BURST_WRAP) ? 4'h3 : 4'($urandom);
         a = 32'(($urandom % 16) * 4);
         if (bt == `AXS_BURST_INCR) a = 32'(($urandom % (16 - ln)) * 4);
         rv = $urandom;
         wr_burst(rv[3:0], a, ln, bt, rv[3:0], 4'h0, `AXS_RESP_OKAY);
         rd_burst(rv[7:4], a, ln, bt, `AXS_RESP_OKAY);
      end
      slow <= 1'b0;
      wr_burst(4'h5, 32'h3f8, 4'h3, `AXS_BURST_INCR, 4'h5, 4'h0, `AXS_RESP_DECERR);
      rd_burst(4'h6, 32'h800, 4'h2, `AXS_BURST_INCR, `AXS_RESP_DECERR);
      rd_burst(4'h7, 32'h0, 4'h0, 2'h3, `AXS_RESP_SLVERR);
      wr_burst(4'h8, 32'h200, 4'h1, `AXS_BURST_INCR, 4'h9, 4'h0, `AXS_RESP_SLVERR);
      apb(1'b1, `AXS_CTRL_OFS, 32'h3, rv);
      wr_burst(4'h2, 32'h0, 4'h0, `AXS_BURST_INCR, 4'h2, 4'hf, `AXS_RESP_SLVERR);
      rd_burst(4'h2, 32'h0, 4'h0, `AXS_BURST_INCR, `AXS_RESP_SLVERR);
      apb(1'b1, `AXS_CTRL_OFS, `AXS_CTRL_RST, rv);
      rd_burst(4'h1, 32'h0, 4'h3, `AXS_BURST_INCR, `AXS_RESP_OKAY);
      apb(1'b0, `AXS_WCOUNT_OFS, 32'h0, rv);
      chk(rv, 32'(nw));
      apb(1'b0, `AXS_RCOUNT_OFS, 32'h0, rv);
      chk(rv, 32'(nr));
      for (int i = 0; i < 2; i++) begin
         csysreq <= 1'b0;
         n = 0;
         do step(n); while (csysack);
         chk(32'(awready), 32'(i));
         if (i == 0) do step(n); while (cactive);
         chk(32'(cactive), 32'(i));
         csysreq <= 1'b1;
         do step(n); while (!csysack);
         apb(1'b1, `AXS_CTRL_OFS, 32'h0, rv);
      end
      tally_and_finish();
   end
endmodule // axs_slave_tb
`default_nettype wire
